// ===== logic/iod_decoder.sv
// i/o space access decoder with core and extended i/o register banks
// assumes the core holds op stable for one cycle; answers one cycle later
// Contract
// - every i/o location, and outside legacy mode every extended location, is reachable by memory read and write.
// - port read and port write use i/o numbers 0x00 to 0x3f, 64 locations.
// - a data address maps to i/o number by subtracting 0x20.
// - bit set, bit clear and bit tests act only on i/o numbers 0x00 to 0x1f.
// - extended locations 0x60 to 0xff are reached only by memory read/write.
// - in legacy mode the extended range is reported as ordinary sram.
// - flagged bits clear on a written one and hold on a written zero.
// - bit set/clear write back the whole byte, clearing flags read as set, except the flag that a bit clear targets.
`timescale 1ns/1ps
`default_nettype none
module iod_decoder #(
  parameter logic [iod_pkg::IO_COUNT*8-1:0] IO_IMPL = {64{8'hff}},
  parameter logic [iod_pkg::IO_COUNT*8-1:0] IO_W1C = {64{8'h00}},
  parameter logic [iod_pkg::EXT_COUNT*8-1:0] EXT_IMPL = {160{8'hff}},
  parameter logic [iod_pkg::EXT_COUNT*8-1:0] EXT_W1C = {160{8'h00}}
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic legacyMode,
  input wire iod_pkg::iod_op_t op,
  input wire logic [iod_pkg::ADDR_W-1:0] addr,
  input wire logic [2:0] bitSel,
  input wire logic [iod_pkg::DATA_W-1:0] wrData,
  input wire logic [iod_pkg::IO_COUNT*8-1:0] ioSetFlags,
  input wire logic [iod_pkg::EXT_COUNT*8-1:0] extSetFlags,
  output logic [iod_pkg::DATA_W-1:0] rdData,
  output logic rdValid,
  output logic bitTrue,
  output logic opRefused,
  output logic sramSelect,
  output logic [iod_pkg::IO_COUNT*8-1:0] ioRegs,
  output logic [iod_pkg::EXT_COUNT*8-1:0] extRegs
);
  import iod_pkg::*;

  function automatic iod_region_t region_of(input logic [ADDR_W-1:0] a,
                                            input logic legacy);
    if (a >= IO_DATA_FIRST && a <= IO_DATA_LAST) begin
      region_of = RG_IO;
    end else if (a >= EXT_FIRST && a <= EXT_LAST) begin
      region_of = legacy ? RG_SRAM : RG_EXT;
    end else begin
      region_of = RG_NONE;
    end
  endfunction : region_of

  // i/o numbers reached by the port read and write ops
  function automatic logic port_reachable(input logic [ADDR_W-1:0] a);
    port_reachable = (a <= ADDR_W'(IO_LAST));
  endfunction : port_reachable

  // i/o numbers reached by the single-bit ops
  function automatic logic bit_reachable(input logic [ADDR_W-1:0] a);
    bit_reachable = (a <= ADDR_W'(BIT_IO_LAST));
  endfunction : bit_reachable

  // one-hot mask for a bit index
  function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] sel);
    bit_mask = DATA_W'(1) << sel;
  endfunction : bit_mask

  logic [ADDR_W-1:0] dataIdx;
  iod_region_t memRegion;
  logic ioHit;
  logic extHit;
  logic [5:0] ioIdx;
  logic [EXT_IDX_W-1:0] extIdx;
  logic ioWrite;
  logic extWrite;
  logic [DATA_W-1:0] ioWord;
  logic [DATA_W-1:0] curIo;
  logic [DATA_W-1:0] curExt;
  logic [DATA_W-1:0] next_rdData;
  logic next_rdValid;
  logic next_bitTrue;
  logic next_opRefused;
  logic next_sramSelect;
  logic [IO_COUNT*8-1:0] next_ioRegs;
  logic [EXT_COUNT*8-1:0] next_extRegs;

  // decode op and address into a target byte
  always_comb begin
    memRegion = region_of(addr, legacyMode);
    dataIdx = addr - IO_DATA_OFFSET;
    extIdx = EXT_IDX_W'(addr - EXT_FIRST);
    ioHit = 1'b0;
    extHit = 1'b0;
    ioIdx = 6'h00;
    ioWrite = 1'b0;
    extWrite = 1'b0;
    next_opRefused = 1'b0;
    next_sramSelect = 1'b0;
    case (op)
      OP_NONE: begin
        ioHit = 1'b0;
      end
      OP_PORT_READ: begin
        ioHit = port_reachable(addr);
        ioIdx = addr[5:0];
        next_opRefused = !ioHit;
      end
      OP_PORT_WRITE: begin
        ioHit = port_reachable(addr);
        ioIdx = addr[5:0];
        ioWrite = ioHit;
        next_opRefused = !ioHit;
      end
      OP_MEMORY_READ: begin
        ioHit = (memRegion == RG_IO);
        extHit = (memRegion == RG_EXT);
        ioIdx = dataIdx[5:0];
        next_sramSelect = (memRegion == RG_SRAM);
        next_opRefused = (memRegion == RG_NONE);
      end
      OP_MEMORY_WRITE: begin
        ioHit = (memRegion == RG_IO);
        extHit = (memRegion == RG_EXT);
        ioIdx = dataIdx[5:0];
        next_sramSelect = (memRegion == RG_SRAM);
        ioWrite = ioHit;
        extWrite = extHit;
        next_opRefused = (memRegion == RG_NONE);
      end
      OP_BIT_SET: begin
        ioHit = bit_reachable(addr);
        ioIdx = addr[5:0];
        ioWrite = ioHit;
        next_opRefused = !ioHit;
      end
      OP_BIT_CLEAR: begin
        ioHit = bit_reachable(addr);
        ioIdx = addr[5:0];
        ioWrite = ioHit;
        next_opRefused = !ioHit;
      end
      OP_BIT_TEST: begin
        ioHit = bit_reachable(addr);
        ioIdx = addr[5:0];
        next_opRefused = !ioHit;
      end
      default: begin
        ioHit = 1'b0;
      end
    endcase
  end

  // answer and write-back byte for the decoded request
  always_comb begin
    curIo = ioRegs[ioIdx*8 +: 8] & IO_IMPL[ioIdx*8 +: 8];
    curExt = extHit ? (extRegs[extIdx*8 +: 8] & EXT_IMPL[extIdx*8 +: 8])
                    : ZERO_BYTE;
    // whole byte read back, one bit altered, all written
    ioWord = wrData;
    if (op == OP_BIT_SET) begin
      ioWord = curIo | bit_mask(bitSel);
    end else if (op == OP_BIT_CLEAR) begin
      ioWord = curIo & ~bit_mask(bitSel);
    end
    next_rdValid = ioHit || extHit || next_sramSelect;
    next_rdData = ZERO_BYTE;
    if (op == OP_PORT_READ || op == OP_MEMORY_READ) begin
      next_rdData = ioHit ? curIo : curExt;
    end
    next_bitTrue = ioHit && (op == OP_BIT_TEST) && curIo[bitSel];
  end

  // next value of every byte, one process each
  genvar gi;
  generate
    for (gi = 0; gi < IO_COUNT; gi++) begin : g_io
      always_comb begin
        logic [7:0] w;
        w = (ioWrite && ioIdx == 6'(gi)) ? ioWord : 8'h00;
        // ones clear flags, zeros hold; plain bits take the byte
        next_ioRegs[gi*8 +: 8] = IO_IMPL[gi*8 +: 8] & (
          (IO_W1C[gi*8 +: 8] & ((ioRegs[gi*8 +: 8] & ~w)
                                | ioSetFlags[gi*8 +: 8])) |
          (~IO_W1C[gi*8 +: 8] & ((ioWrite && ioIdx == 6'(gi))
                                 ? w : ioRegs[gi*8 +: 8])));
      end
    end
    for (gi = 0; gi < EXT_COUNT; gi++) begin : g_ext
      always_comb begin
        logic hit;
        hit = extWrite && extIdx == EXT_IDX_W'(gi);
        next_extRegs[gi*8 +: 8] = EXT_IMPL[gi*8 +: 8] & (
          (EXT_W1C[gi*8 +: 8] & ((extRegs[gi*8 +: 8] &
                                  ~(hit ? wrData : 8'h00))
                                 | extSetFlags[gi*8 +: 8])) |
          (~EXT_W1C[gi*8 +: 8] & (hit ? wrData
                                      : extRegs[gi*8 +: 8])));
      end
    end
  endgenerate

  // register bank storage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ioRegs <= {IO_COUNT{REG_RESET}};
      extRegs <= {EXT_COUNT{REG_RESET}};
    end else begin
      ioRegs <= next_ioRegs;
      extRegs <= next_extRegs;
    end
  end

  // one-cycle answer to the core
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= ZERO_BYTE;
      rdValid <= 1'b0;
      bitTrue <= 1'b0;
      opRefused <= 1'b0;
      sramSelect <= 1'b0;
    end else begin
      rdData <= next_rdData;
      rdValid <= next_rdValid;
      bitTrue <= next_bitTrue;
      opRefused <= next_opRefused;
      sramSelect <= next_sramSelect;
    end
  end
endmodule : iod_decoder
`default_nettype wire

// ===== logic/iod_pkg.sv
// constants for the i/o space access decoder
// assumes a cpu core on the same clock drives one request per cycle
package iod_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [7:0] IO_LAST = 8'h3f;
  localparam logic [7:0] BIT_IO_LAST = 8'h1f;
  localparam logic [ADDR_W-1:0] IO_DATA_OFFSET = 16'h0020;
  localparam logic [ADDR_W-1:0] IO_DATA_FIRST = 16'h0020;
  localparam logic [ADDR_W-1:0] IO_DATA_LAST = 16'h005f;
  localparam logic [ADDR_W-1:0] EXT_FIRST = 16'h0060;
  localparam logic [ADDR_W-1:0] EXT_LAST = 16'h00ff;
  localparam int IO_COUNT = 64;
  localparam int EXT_COUNT = 160;
  localparam int EXT_IDX_W = 8;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_PORT_READ = 3'b001,
    OP_PORT_WRITE = 3'b010,
    OP_MEMORY_READ = 3'b011,
    OP_MEMORY_WRITE = 3'b100,
    OP_BIT_SET = 3'b101,
    OP_BIT_CLEAR = 3'b110,
    OP_BIT_TEST = 3'b111
  } iod_op_t;
  typedef enum logic [1:0] {
    RG_NONE = 2'b00,
    RG_IO = 2'b01,
    RG_EXT = 2'b10,
    RG_SRAM = 2'b11
  } iod_region_t;
endpackage : iod_pkg

// ===== verif/iod_core_model.sv
// cpu core model issuing decoder requests
// assumes the decoder takes a request at each rising edge
`timescale 1ns/1ps
`default_nettype none
module iod_core_model import iod_pkg::*; (
  input wire logic sys_clk,
  output iod_op_t op,
  output logic [15:0] addr,
  output logic [2:0] bitSel,
  output logic [7:0] wrData
);
  initial begin op = OP_NONE; addr = '0; bitSel = '0; wrData = '0; end
  task automatic issue(iod_op_t o, logic [15:0] a, logic [2:0] b,
    logic [7:0] w);
    @(posedge sys_clk);
    op <= o; addr <= a; bitSel <= b; wrData <= w;
  endtask : issue
  task automatic idle();
    @(posedge sys_clk);
    op <= OP_NONE; addr <= ~addr; wrData <= ~wrData; // no stale bus
  endtask : idle
endmodule : iod_core_model
`default_nettype wire

// ===== verif/iod_decoder_sva.sv
// answer checks for the i/o access decoder
// bound onto iod_decoder from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module iod_decoder_sva import iod_pkg::*; (
  input wire logic sys_clk, rstn, legacyMode, rdValid, bitTrue,
  input wire logic opRefused, sramSelect,
  input wire iod_op_t op,
  input wire logic [15:0] addr,
  input wire logic [2:0] bitSel,
  input wire logic [7:0] wrData, rdData,
  input wire logic [511:0] ioSetFlags, ioRegs
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_range_refuse: assert property (((op inside {OP_PORT_READ,
    OP_PORT_WRITE} && addr > 16'h3f) || (op >= OP_BIT_SET && addr > 16'h1f))
    |=> opRefused) else $error("range not refused");
  a_port_read: assert property (op == OP_PORT_READ && addr <= 16'h3f
    |=> rdValid && rdData == $past(ioRegs[{addr[5:0], 3'h0} +: 8]))
    else $error("port read");
  a_data_offset: assert property (op == OP_MEMORY_READ && addr
    inside {[16'h20:16'h5f]} |=> rdData ==
    $past(ioRegs[{6'(addr - 16'h20), 3'h0} +: 8])) else $error("offset");
  a_bit_test: assert property (op == OP_BIT_TEST && addr <= 16'h1f
    |=> bitTrue == $past(ioRegs[{addr[4:0], bitSel}])) else $error("test");
  a_legacy_sram: assert property (op == OP_MEMORY_READ && legacyMode &&
    addr inside {[16'h60:16'hff]} |=> sramSelect && rdData == 8'h00)
    else $error("legacy");
  a_w1c_flag: assert property (op == OP_PORT_WRITE && addr == 16'h3 &&
    !ioSetFlags[24] |=> ioRegs[24] == ($past(ioRegs[24]) &&
    !$past(wrData[0]))) else $error("w1c");
  a_rmw_clear: assert property (op == OP_BIT_SET && addr == 16'h3 &&
    !ioSetFlags[24] |=> !ioRegs[24]) else $error("rmw");
  a_refused_hold: assert property (opRefused |-> $stable(ioRegs))
    else $error("refused changed state");
endmodule : iod_decoder_sva
`default_nettype wire

// ===== verif/iod_decoder_tb.sv
// testbench: core model requests, queued answer expectations
// assumes iod_pkg, iod_decoder and iod_core_model compiled first
`timescale 1ns/1ps
`default_nettype none
module iod_decoder_tb;
  import iod_pkg::*;
  localparam logic [11:0] V = 12'h800, B = 12'h400, R = 12'h200;
  logic sys_clk, rstn, legacyMode, pend, rdValid, bitTrue, opRefused;
  logic sramSelect;
  logic [511:0] ioSetFlags, ioRegs;
  iod_op_t op;
  logic [15:0] addr, a;
  logic [2:0] bitSel;
  logic [7:0] wrData, rdData, d;
  logic [11:0] expQ[$], e;
  int err_count, comparisons;
  iod_core_model i_iod_core_model(.sys_clk, .op, .addr, .bitSel, .wrData);
  iod_decoder #(.IO_IMPL({{59{8'hff}}, 8'h0f, {4{8'hff}}}),
    .IO_W1C({{60{8'h00}}, 8'h01, {3{8'h00}}})) i_iod_decoder(.sys_clk,
    .rstn, .legacyMode, .op, .addr, .bitSel, .wrData, .ioSetFlags,
    .extSetFlags('0), .rdData, .rdValid, .bitTrue, .opRefused,
    .sramSelect, .ioRegs, .extRegs());
  task automatic rq(iod_op_t o, logic [15:0] x, logic [2:0] b,
    logic [7:0] w, logic [11:0] ex);
    expQ.push_back(ex);
    i_iod_core_model.issue(o, x, b, w);
  endtask : rq
  task automatic flag();
    i_iod_core_model.idle();
    ioSetFlags[24] <= 1'b1;
    @(posedge sys_clk) ioSetFlags[24] <= 1'b0;
  endtask : flag
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  initial begin sys_clk = 0; forever #25 sys_clk = ~sys_clk; end
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    print_verdict();
  end
  always @(posedge sys_clk) begin
    pend <= rstn && op != OP_NONE;
    if (pend) begin
      e = expQ.pop_front();
      comparisons++;
      if ({rdValid, bitTrue, opRefused, sramSelect, rdData} !== e) begin
        err_count++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e,
          {rdValid, bitTrue, opRefused, sramSelect, rdData});
      end
    end
  end
  initial begin
    rstn = 0; legacyMode = 0; ioSetFlags = '0; pend = 0;
    void'($urandom(74976));
    repeat (20) @(posedge sys_clk);
    rstn <= 1;
    for (int i = 0; i < 8; i++) begin
      a = 16'h10 + 16'($urandom % 48); d = 8'($urandom);
      rq(OP_PORT_WRITE, a, 0, d, V);
      rq(OP_PORT_READ, a, 0, 0, V | d);
      rq(OP_MEMORY_READ, a + 16'h20, 0, 0, V | d);
      rq(OP_BIT_SET, 16'h11, 3'(i), 0, V);
      rq(OP_BIT_TEST, 16'h11, 3'(i), 0, V | B);
      rq(OP_BIT_CLEAR, 16'h11, 3'(i), 0, V);
      rq(OP_BIT_TEST, 16'h11, 3'(i), 0, V);
      a = 16'h60 + 16'($urandom % 160);
      rq(OP_MEMORY_WRITE, a, 0, d, V);
      rq(OP_MEMORY_READ, a, 0, 0, V | d);
      rq(OP_PORT_READ, a, 0, 0, R);
      rq(OP_BIT_CLEAR, 16'h20, 3'(i), 0, R);
    end
    $display("bank access test done");
    i_iod_core_model.idle(); legacyMode <= 1;
    rq(OP_MEMORY_READ, a, 0, 0, V | 12'h100);
    rq(OP_MEMORY_READ, 16'h1f, 0, 0, R);
    i_iod_core_model.idle(); legacyMode <= 0;
    $display("legacy test done");
    flag();
    rq(OP_PORT_READ, 3, 0, 0, V | 8'h01);
    rq(OP_MEMORY_WRITE, 16'h23, 0, 0, V);
    rq(OP_PORT_READ, 3, 0, 0, V | 8'h01);
    rq(OP_PORT_WRITE, 3, 0, 8'h01, V);
    rq(OP_PORT_READ, 3, 0, 0, V);
    flag();
    rq(OP_BIT_SET, 3, 2, 0, V);
    rq(OP_PORT_READ, 3, 0, 0, V | 8'h04);
    rq(OP_PORT_WRITE, 4, 0, 8'hff, V);
    rq(OP_PORT_READ, 4, 0, 0, V | 8'h0f);
    i_iod_core_model.idle();
    repeat (3) @(posedge sys_clk);
    $display("flag test done");
    print_verdict();
  end
endmodule : iod_decoder_tb
bind iod_decoder iod_decoder_sva i_iod_decoder_sva(.sys_clk, .rstn,
  .legacyMode, .rdValid, .bitTrue, .opRefused, .sramSelect, .op, .addr,
  .bitSel, .wrData, .rdData, .ioSetFlags, .ioRegs);
`default_nettype wire
